// *** rtl/spp_bank.sv ***
// One bidirectional port bank: settings, pad control and input sampling
module spp_bank
  import spp_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         wr_en,
  input  wire spp_sel_t     wr_sel,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] take_mask,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pin_pu,
  output logic      [W-1:0] pin_val,
  output logic      [W-1:0] dir_q,
  output logic      [W-1:0] pull_q
);

  logic [W-1:0] data_r;
  logic [W-1:0] dir_r;
  logic [W-1:0] pull_r;
  logic [W-1:0] sync1_r;
  logic [W-1:0] sync2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Per-bit settings written by the core
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_r <= SPP_DATA_RST[W-1:0];
      dir_r  <= SPP_DIR_RST[W-1:0];
      pull_r <= SPP_PULL_RST[W-1:0];
    end else if (wr_en) begin
      unique case (wr_sel)
        SPP_SEL_DATA: data_r <= wr_data;
        SPP_SEL_DIR:  dir_r  <= wr_data;   // Each bit input or output [R01] [R07]
        SPP_SEL_PULL: pull_r <= wr_data;   // Per-bit pull-up choice [R03] [R07]
        default:      data_r <= data_r;
      endcase
    end
  end

  // Two-stage sampling of the pin levels
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_r <= SPP_SYNC_RST[W-1:0];
      sync2_r <= SPP_SYNC_RST[W-1:0];
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive; reset releases the pins without waiting for a clock edge
  assign pin_o   = data_r;
  assign pin_oe  = dir_r & ~take_mask & {W{~rst}};         // [R04] [R08] [R09]
  // Pull-up only on an input whose pull-up is selected
  assign pin_pu  = pull_r & ~dir_r & ~take_mask & {W{~rst}}; // [R11]
  assign pin_val = sync2_r;
  assign dir_q   = dir_r;
  assign pull_q  = pull_r;

endmodule

// *** rtl/spp_port_slice.sv ***
// Shared, general and preceding port pin slice with converter and test functions
//
// Operation
// R01: Shared port is 8-bit GPIO when converter unused
// R02: Shared pins route to converter when used
// R03: Shared port pull-up chosen per bit
// R04: Shared pins float during reset, clock-free
// R05: Test pull-ups stay on when test enabled
// R06: Shared port carries the test interface pins
// R07: General port is 6-bit, per-bit pull-ups
// R08: General pins float during reset, clock-free
// R09: Preceding port pins float during reset
// R10: Reset pin held low beyond minimum pulse; this slice takes rst as given and does not stretch it
// R11: Pull-up only on selected input pins; with the test interface on, shared bits 7, 5 and 4 are pulled up regardless
module spp_port_slice
  import spp_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire spp_wr_t               cpu_wr,
  input  wire logic                  adc_en,
  input  wire logic [2:0]            adc_chan,
  input  wire logic                  jtag_en,
  input  wire logic                  jtag_tdo,
  input  wire logic                  jtag_tdo_en,
  input  wire logic [SPP_SH_W-1:0]   sh_pin_i,
  output spp_pad_t                   sh_pad,
  output logic      [SPP_SH_W-1:0]   sh_analog_sel,
  output logic                       jtag_tck,
  output logic                       jtag_tms,
  output logic                       jtag_tdi,
  input  wire logic [SPP_GEN_W-1:0]  gen_pin_i,
  output spp_pad_t                   gen_pad,
  input  wire logic [SPP_PREV_W-1:0] prev_pin_i,
  output spp_pad_t                   prev_pad,
  output spp_rd_t                    sh_rd,
  output spp_rd_t                    gen_rd,
  output spp_rd_t                    prev_rd
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Write strobe for one port
  function automatic logic port_hit(input spp_wr_t w, input spp_port_t p);
    return w.wr && (w.port == p);
  endfunction

  // One-hot select of a converter channel
  function automatic logic [7:0] chan_onehot(input logic [2:0] ch);
    logic [7:0] oh;
    oh = 8'h00;
    oh[ch] = 1'b1;
    return oh;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Shared port

  logic [SPP_SH_W-1:0] sh_take;
  logic [SPP_SH_W-1:0] sh_o;
  logic [SPP_SH_W-1:0] sh_oe;
  logic [SPP_SH_W-1:0] sh_pu;
  logic [SPP_SH_W-1:0] sh_val;
  logic [SPP_SH_W-1:0] sh_dir;
  logic [SPP_SH_W-1:0] sh_pull;

  // Pins claimed by the converter or the test interface leave the GPIO path
  always_comb begin
    sh_take = 8'h00;
    if (adc_en) begin
      sh_take = 8'hFF;                          // Whole port goes analog [R01] [R02]
    end
    if (jtag_en) begin
      sh_take = sh_take | SPP_JTAG_MASK;        // Test pins override [R06]
    end
  end

  spp_bank #(
    .W (SPP_SH_W)
  ) u_sh_bank (
    .mclk      (mclk),
    .rst       (rst),
    .wr_en     (port_hit(cpu_wr, SPP_PORT_SHARED)),
    .wr_sel    (cpu_wr.sel),
    .wr_data   (cpu_wr.data),
    .take_mask (sh_take),
    .pin_i     (sh_pin_i),
    .pin_o     (sh_o),
    .pin_oe    (sh_oe),
    .pin_pu    (sh_pu),
    .pin_val   (sh_val),
    .dir_q     (sh_dir),
    .pull_q    (sh_pull)
  );

  // Pad controls of the shared port with the test interface laid on top
  always_comb begin
    sh_pad.o  = sh_o;
    sh_pad.oe = sh_oe;
    sh_pad.pu = sh_pu;
    if (jtag_en) begin
      sh_pad.o[SPP_TDO_BIT]  = jtag_tdo;                          // [R06]
      sh_pad.oe[SPP_TDO_BIT] = jtag_tdo_en & ~rst;                // [R04]
      // Test pull-ups hold even through reset
      sh_pad.pu = sh_pad.pu | SPP_JTAG_PU_MASK;                   // [R05]
    end
  end

  // Converter channel switch, closed only while the converter is in use
  assign sh_analog_sel = adc_en ? chan_onehot(adc_chan) : 8'h00;   // [R02]

  // Test inputs go raw to the test logic, which runs on its own clock
  assign jtag_tck = jtag_en & sh_pin_i[SPP_TCK_BIT];             // [R06]
  assign jtag_tms = jtag_en & sh_pin_i[SPP_TMS_BIT];
  assign jtag_tdi = jtag_en & sh_pin_i[SPP_TDI_BIT];

  // Readback of the shared port
  assign sh_rd.pin  = sh_val;
  assign sh_rd.data = sh_o;
  assign sh_rd.dir  = sh_dir;
  assign sh_rd.pull = sh_pull;

  ////////////////////////////////////////////////////////////////////////////
  // General port

  logic [SPP_GEN_W-1:0] gen_o;
  logic [SPP_GEN_W-1:0] gen_oe;
  logic [SPP_GEN_W-1:0] gen_pu;
  logic [SPP_GEN_W-1:0] gen_val;
  logic [SPP_GEN_W-1:0] gen_dir;
  logic [SPP_GEN_W-1:0] gen_pull;

  spp_bank #(
    .W (SPP_GEN_W)
  ) u_gen_bank (
    .mclk      (mclk),
    .rst       (rst),
    .wr_en     (port_hit(cpu_wr, SPP_PORT_GEN)),              // [R07]
    .wr_sel    (cpu_wr.sel),
    .wr_data   (cpu_wr.data[SPP_GEN_W-1:0]),
    .take_mask (6'h00),
    .pin_i     (gen_pin_i),
    .pin_o     (gen_o),
    .pin_oe    (gen_oe),
    .pin_pu    (gen_pu),
    .pin_val   (gen_val),
    .dir_q     (gen_dir),
    .pull_q    (gen_pull)
  );

  // Six pins in the low bits, upper pads never driven or pulled
  assign gen_pad.o  = {2'h0, gen_o};
  assign gen_pad.oe = {2'h0, gen_oe};                           // [R08]
  assign gen_pad.pu = {2'h0, gen_pu};

  // Readback of the general port
  assign gen_rd.pin  = {2'h0, gen_val};
  assign gen_rd.data = {2'h0, gen_o};
  assign gen_rd.dir  = {2'h0, gen_dir};
  assign gen_rd.pull = {2'h0, gen_pull};

  ////////////////////////////////////////////////////////////////////////////
  // Preceding port

  logic [SPP_PREV_W-1:0] prev_o;
  logic [SPP_PREV_W-1:0] prev_oe;
  logic [SPP_PREV_W-1:0] prev_pu;
  logic [SPP_PREV_W-1:0] prev_val;
  logic [SPP_PREV_W-1:0] prev_dir;
  logic [SPP_PREV_W-1:0] prev_pull;

  spp_bank #(
    .W (SPP_PREV_W)
  ) u_prev_bank (
    .mclk      (mclk),
    .rst       (rst),
    .wr_en     (port_hit(cpu_wr, SPP_PORT_PREV)),
    .wr_sel    (cpu_wr.sel),
    .wr_data   (cpu_wr.data),
    .take_mask (8'h00),
    .pin_i     (prev_pin_i),
    .pin_o     (prev_o),
    .pin_oe    (prev_oe),
    .pin_pu    (prev_pu),
    .pin_val   (prev_val),
    .dir_q     (prev_dir),
    .pull_q    (prev_pull)
  );

  // Pad controls, released by reset inside the bank
  assign prev_pad.o  = prev_o;
  assign prev_pad.oe = prev_oe;                                  // [R09]
  assign prev_pad.pu = prev_pu;

  // Readback of the preceding port
  assign prev_rd.pin  = prev_val;
  assign prev_rd.data = prev_o;
  assign prev_rd.dir  = prev_dir;
  assign prev_rd.pull = prev_pull;

endmodule

// *** shared/spp_pkg.sv ***
// Shared constants and carrier types for the port pin slice
package spp_pkg;

  // Port widths
  localparam int unsigned SPP_SH_W   = 8;
  localparam int unsigned SPP_GEN_W  = 6;
  localparam int unsigned SPP_PREV_W = 8;

  // Alternate-function bit positions on the shared port
  localparam int unsigned SPP_TCK_BIT = 4;
  localparam int unsigned SPP_TMS_BIT = 5;
  localparam int unsigned SPP_TDO_BIT = 6;
  localparam int unsigned SPP_TDI_BIT = 7;

  // Test-pin pull-up mask (bits 7, 5 and 4)
  localparam logic [7:0] SPP_JTAG_PU_MASK = 8'hB0;
  // Shared-port bits taken from the GPIO function while the test interface is on
  localparam logic [7:0] SPP_JTAG_MASK    = 8'hF0;

  // Values after reset of the per-bit settings
  localparam logic [7:0] SPP_DATA_RST = 8'h00;
  localparam logic [7:0] SPP_DIR_RST  = 8'h00;
  localparam logic [7:0] SPP_PULL_RST = 8'h00;
  localparam logic [7:0] SPP_SYNC_RST = 8'h00;

  // Which port a settings write goes to
  typedef enum logic [1:0] {
    SPP_PORT_SHARED = 2'b00,
    SPP_PORT_GEN    = 2'b01,
    SPP_PORT_PREV   = 2'b10
  } spp_port_t;

  // Which per-bit setting a write changes
  typedef enum logic [1:0] {
    SPP_SEL_DATA = 2'b00,
    SPP_SEL_DIR  = 2'b01,
    SPP_SEL_PULL = 2'b10
  } spp_sel_t;

  // Settings write from the core
  typedef struct packed {
    logic       wr;
    spp_port_t  port;
    spp_sel_t   sel;
    logic [7:0] data;
  } spp_wr_t;

  // Pad controls for up to eight pins
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
  } spp_pad_t;

  // Readback of one port
  typedef struct packed {
    logic [7:0] pin;
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] pull;
  } spp_rd_t;

endpackage

// *** sim/spp_board.sv ***
// Board model resolving each pad wire
module spp_board
  import spp_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire spp_pad_t     pad,
  input  wire logic [W-1:0] ext,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] tog = '0;
  // Unpulled floating wire flips every cycle
  always_ff @(posedge mclk) tog <= ~tog;
  // Chip drive wins, then board drive, then pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin[i] = pad.oe[i] ? pad.o[i] : ext_en[i] ? ext[i] : pad.pu[i] | tog[i];
    end
  end
endmodule

// *** sim/spp_chk_assertions.sv ***
// Concurrent checks on the port pin slice pads and readback
module spp_chk
  import spp_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       adc_en,
  input wire logic [2:0] adc_chan,
  input wire logic       jtag_en,
  input wire logic [7:0] sh_pin_i,
  input wire logic       jtag_tck,
  input wire spp_pad_t   sh_pad,
  input wire logic [7:0] sh_analog_sel,
  input wire logic [5:0] gen_pin_i,
  input wire spp_pad_t   gen_pad,
  input wire spp_pad_t   prev_pad,
  input wire spp_rd_t    gen_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  property p_sh_rst;
    rst |-> sh_pad.oe == 8'h00 && sh_pad.pu == (jtag_en ? SPP_JTAG_PU_MASK : 8'h00);
  endproperty
  a_sh_rst: assert property (p_sh_rst) else $error("shared pad live in reset");
  property p_jpu; jtag_en |-> (sh_pad.pu & SPP_JTAG_PU_MASK) == SPP_JTAG_PU_MASK; endproperty
  a_jpu: assert property (p_jpu) else $error("test pull-ups off");
  property p_gen_rst; rst |-> (gen_pad.oe | gen_pad.pu) == 8'h00; endproperty
  a_gen_rst: assert property (p_gen_rst) else $error("general pad live in reset");
  property p_prev_rst; rst |-> (prev_pad.oe | prev_pad.pu) == 8'h00; endproperty
  a_prev_rst: assert property (p_prev_rst) else $error("prev pad live in reset");
  property p_adc;
    adc_en |-> sh_analog_sel == (8'h01 << adc_chan) && sh_pad.oe == 8'h00;
  endproperty
  a_adc: assert property (p_adc) else $error("converter routing wrong");
  property p_tck; jtag_tck == (jtag_en & sh_pin_i[SPP_TCK_BIT]); endproperty
  a_tck: assert property (p_tck) else $error("test clock wrong");
  property p_gpu; disable iff (rst) gen_pad.pu == (gen_rd.pull & ~gen_rd.dir); endproperty
  a_gpu: assert property (p_gpu) else $error("general pull-up wrong");
  property p_sync; disable iff (rst) !rst ##1 !rst |=> gen_rd.pin[5:0] == $past(gen_pin_i, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("general pin readback wrong");
  c_jrst: cover property (rst && jtag_en);
  c_adc: cover property (adc_en && adc_chan == 3'h7);
  c_pull: cover property (gen_pad.pu != 8'h00);
endmodule
bind spp_port_slice spp_chk u_chk (.mclk(mclk), .rst(rst), .adc_en(adc_en),
  .adc_chan(adc_chan), .jtag_en(jtag_en), .sh_pin_i(sh_pin_i), .jtag_tck(jtag_tck),
  .sh_pad(sh_pad), .sh_analog_sel(sh_analog_sel), .gen_pin_i(gen_pin_i),
  .gen_pad(gen_pad), .prev_pad(prev_pad), .gen_rd(gen_rd));

// *** sim/testbench.sv ***
// Self-checking bench for the port pin slice
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import spp_pkg::*;
  logic        mclk, rst, adc_en, jtag_en, tdo, tdo_en, tck, tms, tdi;
  logic [2:0]  chan;
  spp_wr_t     cpu_wr;
  logic [31:0] seed = 32'h3BF4;
  logic [7:0]  dat [3], dir [3], pul [3], x [3], xe [3], sh_sel, sh_pin, pv_pin;
  logic [5:0]  gn_pin;
  spp_pad_t    pd [3];
  spp_rd_t     rd [3];
  int          err_count, check_count, md;
  spp_port_slice dut (.mclk(mclk), .rst(rst), .cpu_wr(cpu_wr), .adc_en(adc_en),
    .adc_chan(chan), .jtag_en(jtag_en), .jtag_tdo(tdo), .jtag_tdo_en(tdo_en),
    .sh_pin_i(sh_pin), .sh_pad(pd[0]), .sh_analog_sel(sh_sel), .jtag_tck(tck),
    .jtag_tms(tms), .jtag_tdi(tdi), .gen_pin_i(gn_pin), .gen_pad(pd[1]), .prev_pin_i(pv_pin),
    .prev_pad(pd[2]), .sh_rd(rd[0]), .gen_rd(rd[1]), .prev_rd(rd[2]));
  spp_board #(.W(8)) b_sh (.mclk(mclk), .pad(pd[0]), .ext(x[0]), .ext_en(xe[0]), .pin(sh_pin));
  spp_board #(.W(6)) b_gn (.mclk(mclk), .pad(pd[1]), .ext(x[1][5:0]), .ext_en(xe[1][5:0]),
    .pin(gn_pin));
  spp_board #(.W(8)) b_pv (.mclk(mclk), .pad(pd[2]), .ext(x[2]), .ext_en(xe[2]), .pin(pv_pin));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected pad controls of one port
  function automatic spp_pad_t exp_pad(int p);
    logic [7:0] tk;
    tk = p != 0 ? 8'h00 : md == 1 ? 8'hFF : md == 2 ? SPP_JTAG_MASK : 8'h00;
    exp_pad.o = dat[p];
    exp_pad.oe = dir[p] & ~tk;
    exp_pad.pu = pul[p] & ~dir[p] & ~tk;
    if (p == 0 && md == 2) begin
      exp_pad.pu = exp_pad.pu | SPP_JTAG_PU_MASK;
      exp_pad.oe[SPP_TDO_BIT] = tdo_en;
      exp_pad.o[SPP_TDO_BIT] = tdo;
    end
  endfunction
  task automatic check(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One settings write; refused port or field leaves the model alone
  task automatic wr(int p, int s, logic [7:0] d);
    logic [7:0] m;
    m = d & (p == 1 ? 8'h3F : 8'hFF);
    @(negedge mclk);
    cpu_wr <= '{1'b1, spp_port_t'(p[1:0]), spp_sel_t'(s[1:0]), d};
    if (p < 3 && s == 0) dat[p] = m;
    if (p < 3 && s == 1) dir[p] = m;
    if (p < 3 && s == 2) pul[p] = m;
    @(negedge mclk);
    cpu_wr.wr <= 1'b0;
  endtask
  // Compare pads and readback of one port
  task automatic chk(int p);
    spp_pad_t   e;
    logic [7:0] v, k;
    e = exp_pad(p);
    for (int i = 0; i < 8; i++) begin
      v[i] = e.oe[i] ? e.o[i] : xe[p][i] ? x[p][i] : 1'b1;
      k[i] = e.oe[i] | xe[p][i] | e.pu[i];
    end
    check(pd[p].oe, e.oe);
    check(pd[p].pu, e.pu);
    check(pd[p].o & e.oe, e.o & e.oe);
    check(rd[p].dir, dir[p]);
    check(rd[p].pull, pul[p]);
    check(rd[p].data, dat[p]);
    check(rd[p].pin & k, v & k);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Watchdog
  initial begin
    #50us;
    err_count++;
    results();
  end
  // Reset, random traffic, then a reset in mid-run
  initial begin
    logic [31:0] r;
    spp_pad_t    e;
    rst = 1'b1;
    {adc_en, jtag_en, tdo, tdo_en, chan} = '0;
    cpu_wr = '0;
    for (int p = 0; p < 3; p++) {dat[p], dir[p], pul[p], x[p], xe[p]} = '0;
    md = 0;
    repeat (10) @(negedge mclk);
    rst <= 1'b0;
    repeat (60) begin
      r = rnd();
      md = int'(r % 3);
      adc_en <= md == 1;
      jtag_en <= md == 2;
      {chan, tdo, tdo_en} <= r[12:8];
      wr(int'(r[17:16]), int'(r[19:18]), r[31:24]);
      for (int p = 0; p < 3; p++) begin
        e = exp_pad(p);
        r = rnd();
        x[p] = r[7:0];
        xe[p] = r[15:8] & ~e.oe & (p == 1 ? 8'h3F : 8'hFF);
      end
      repeat (3) @(negedge mclk);
      check(sh_sel, md == 1 ? 8'h01 << chan : 8'h00);
      check({7'h00, tck}, {7'h00, md == 2 && sh_pin[4]});
      check({6'h00, tms, tdi}, {6'h00, md == 2 && sh_pin[5], md == 2 && sh_pin[7]});
      for (int p = 0; p < 3; p++) chk(p);
    end
    for (int p = 0; p < 3; p++) wr(p, p == 1 ? 2 : 1, 8'hFF);
    md = 2;
    jtag_en <= 1'b1;
    adc_en <= 1'b0;
    rst <= 1'b1;
    #5;
    check(pd[0].oe, 8'h00);
    check(pd[0].pu, SPP_JTAG_PU_MASK);
    check(pd[1].oe | pd[1].pu, 8'h00);
    check(pd[2].oe | pd[2].pu, 8'h00);
    repeat (10) @(negedge mclk);
    rst <= 1'b0;
    for (int p = 0; p < 3; p++) {dat[p], dir[p], pul[p]} = '0;
    repeat (3) @(negedge mclk);
    for (int p = 0; p < 3; p++) chk(p);
    results();
  end
endmodule
